// ===== design/pvf_panel_format.sv
/*
 * Panel configuration decoder and vertical format controller.
 * Decodes pencil switches, debounces buttons, keeps the working form
 * length, tabs, line counter and spacing, and stores formats in eight
 * retained channels. Assumes inputs synchronous to clk_in and that
 * resetn_in is asserted only at power-up.
 */
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/100ps
`include "pvf_consts.svh"

module pvf_panel_format
  import pvf_pkg::*;
#(
  parameter int          DEB_CYCLES = `PVF_DEB_CYCLES,
  parameter logic [76:0] FIXED_LENS = {7'h42, 7'h3c, 7'h36, 7'h30, 7'h2a,
                                       7'h24, 7'h1e, 7'h18, 7'h12, 7'h0c, 7'h06}
) (
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  // configuration straps
  input  wire pvf_config_t config_in,
  input  wire logic        alt_rate_option_in,
  input  wire logic        online_in,
  // panel pencil switches, bit 0 is switch one
  input  wire logic [6:0]  pencil_in,
  // panel rotaries: 0 is programmed_length_position
  input  wire logic [3:0]  form_len_rot_in,
  input  wire logic [2:0]  channel_rot_in,
  // panel push buttons, high while pressed
  input  wire pvf_buttons_t buttons_in,
  // paper logic: one line advanced in normal operation
  input  wire logic        line_adv_in,
  // register port
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic [15:0]      rdata_out,
  // decoded settings
  output logic [13:0]      baud_out,
  output logic             parallel_out,
  output pvf_parity_t      parity_out,
  output logic             auto_lf_out,
  output logic             perf_skip_out,
  output logic             self_test_run_out,
  // vertical format state
  output logic             setup_mode_out,
  output logic             lpi8_lamp_out,
  output logic [6:0]       form_len_out,
  output logic [6:0]       line_count_out,
  output logic             tab_here_out
);

  // elaboration check: the divider counter is 20 bits wide
  if (DEB_CYCLES < 2 || DEB_CYCLES > 1000000) begin : deb_range_bad
    $error("DEB_CYCLES out of range");
  end

  // ==========================================================
  // helpers
  function automatic logic [13:0] rate_of(input logic [2:0] code, input logic alt);
    unique case (code)
      3'h0: rate_of = 14'd110;
      3'h1: rate_of = alt ? 14'd200 : 14'd150;
      3'h2: rate_of = 14'd300;
      3'h3: rate_of = 14'd1200;
      3'h4: rate_of = 14'd2400;
      3'h5: rate_of = alt ? 14'd600 : 14'd4800;
      3'h6: rate_of = 14'd9600;
      3'h7: rate_of = 14'd0;
    endcase
  endfunction

  function automatic logic len_ok(input logic [6:0] len);
    len_ok = (len >= `PVF_LEN_MIN) && (len <= `PVF_LEN_MAX);
  endfunction

  // ==========================================================
  // debounce: sampled on a divider tick, three equal samples win
  localparam int NIN = 10 + 7;
  logic [19:0]    deb_cnt;
  logic           deb_tick;
  logic [NIN-1:0] raw, samp_a, samp_b, stable, stable_q;
  pvf_buttons_t   press;
  logic [6:0]     sw;

  assign raw = {buttons_in, pencil_in};

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      deb_cnt  <= 20'h0;
      deb_tick <= 1'b0;
    end else begin
      deb_tick <= (deb_cnt == 20'(DEB_CYCLES - 1));
      deb_cnt  <= (deb_cnt == 20'(DEB_CYCLES - 1)) ? 20'h0 : deb_cnt + 20'h1;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      samp_a   <= '0;
      samp_b   <= '0;
      stable   <= '0;
      stable_q <= '0;
    end else begin
      stable_q <= stable;
      if (deb_tick) begin
        samp_a <= raw;
        samp_b <= samp_a;
        // rise on three high samples, fall only on three low ones
        stable <= (raw & samp_a & samp_b) | (stable & (raw | samp_a | samp_b));
      end
    end
  end

  // a button acts once, on the press edge of the debounced level
  assign press = pvf_buttons_t'(stable[NIN-1:7] & ~stable_q[NIN-1:7]);
  assign sw    = stable[6:0];

  // ==========================================================
  // decoded switch settings
  // registered decode
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      baud_out      <= 14'd110;
      parallel_out  <= 1'b0;
      parity_out    <= PVF_PAR_IGNORE;
      auto_lf_out   <= 1'b1;
      perf_skip_out <= 1'b1;
    end else begin
      baud_out     <= rate_of(sw[2:0], alt_rate_option_in);
      parallel_out <= (sw[2:0] == 3'h7);
      if (!sw[3])
        parity_out <= PVF_PAR_IGNORE;
      else
        parity_out <= sw[4] ? PVF_PAR_ODD : PVF_PAR_EVEN;
      auto_lf_out   <= !sw[5];
      perf_skip_out <= !sw[6];
    end
  end

  assign self_test_run_out = setup_mode_out && online_in && !parallel_out;

  // ==========================================================
  // retained channels and shadows, never reset
  // retained storage
  pvf_format_t chan_mem [8];
  logic [2:0]  last_chan;
  logic [6:0]  line_count_nv;

  // ==========================================================
  // working format
  logic         fmt_cfg, fixed_cfg, powered;
  logic [111:0] tabs;
  logic         armed, counting;
  logic [6:0]   next_tab_line;
  logic         sw_store, sw_recall;
  logic [2:0]   sw_chan;

  assign fmt_cfg   = (config_in == PVF_FMT) || (config_in == PVF_FMT_COMP);
  assign fixed_cfg = (config_in == PVF_FIXED) || (config_in == PVF_FIXED_COMP);
  assign sw_store  = wr_in && (addr_in == `PVF_REG_CHAN_CMD) && wdata_in[`PVF_CMD_STORE_BIT];
  assign sw_recall = wr_in && (addr_in == `PVF_REG_CHAN_CMD) && wdata_in[`PVF_CMD_RECALL_BIT];
  assign sw_chan   = wdata_in[2:0];

  // next tab after the current line, else top of form
  always_comb begin
    next_tab_line = 7'h0;
    for (int i = `PVF_MAX_LINES - 1; i >= 0; i--) begin
      if (tabs[i] && 7'(i) > line_count_out && 7'(i) < form_len_out)
        next_tab_line = 7'(i);
    end
  end

  assign tab_here_out = tabs[line_count_out];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      setup_mode_out <= 1'b0;
    else if (press.setup)
      setup_mode_out <= 1'b1;
    else if (press.normal)
      setup_mode_out <= 1'b0;
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      powered        <= 1'b0;
      form_len_out   <= `PVF_LEN_RESET;
      tabs           <= '0;
      lpi8_lamp_out  <= 1'b0;
      line_count_out <= 7'h0;
      armed          <= 1'b0;
      counting       <= 1'b0;
    end else if (!powered) begin
      powered <= 1'b1;
      if (fmt_cfg) begin
        form_len_out   <= chan_mem[last_chan].len;
        tabs           <= chan_mem[last_chan].tabs;
        lpi8_lamp_out  <= chan_mem[last_chan].lpi8;
        line_count_out <= line_count_nv;
      end else if (fixed_cfg && form_len_rot_in != 4'h0 && form_len_rot_in <= 4'hb) begin
        form_len_out <= FIXED_LENS[7*(form_len_rot_in - 4'h1) +: 7];
      end
    end else begin
      if (press.lpi8)
        lpi8_lamp_out <= !lpi8_lamp_out;
      else if (wr_in && addr_in == `PVF_REG_SPACING)
        lpi8_lamp_out <= wdata_in[0];
      if (wr_in && addr_in == `PVF_REG_FORM_LEN && len_ok(wdata_in[6:0]))
        form_len_out <= wdata_in[6:0];
      if (wr_in && addr_in == `PVF_REG_TAB && wdata_in[6:0] < 7'(`PVF_MAX_LINES))
        tabs[wdata_in[6:0]] <= wdata_in[`PVF_TAB_SET_BIT];
      if (press.tab_set)
        tabs[line_count_out] <= 1'b1;
      else if (press.tab_clear)
        tabs[line_count_out] <= 1'b0;
      // line counter: paper advance, line feed, tab
      if (setup_mode_out && press.mark_top && fixed_cfg && form_len_rot_in != 4'h0) begin
        if (form_len_rot_in <= 4'hb)
          form_len_out <= FIXED_LENS[7*(form_len_rot_in - 4'h1) +: 7];
        line_count_out <= 7'h0;
      end else if (setup_mode_out && press.mark_top && config_in != PVF_BASIC) begin
        if (!counting) begin
          line_count_out <= 7'h0;
          counting       <= 1'b1;
          armed          <= 1'b0;
        end else begin
          armed <= 1'b1;
        end
      end else if (setup_mode_out && press.tab) begin
        // advance to next tab or top
        line_count_out <= next_tab_line;
      end else if (press.line_feed || (line_adv_in && !counting)) begin
        if (!counting && line_count_out + 7'h1 >= form_len_out)
          line_count_out <= 7'h0;
        else if (line_count_out < `PVF_LEN_MAX)
          line_count_out <= line_count_out + 7'h1;
      end
      if (press.normal) begin
        if (armed && len_ok(line_count_out)) begin
          form_len_out   <= line_count_out;
          line_count_out <= 7'h0;
        end
        armed    <= 1'b0;
        counting <= 1'b0;
      end
      if (fmt_cfg && ((press.recall && setup_mode_out) || sw_recall)) begin
        form_len_out  <= chan_mem[sw_recall ? sw_chan : channel_rot_in].len;
        tabs          <= chan_mem[sw_recall ? sw_chan : channel_rot_in].tabs;
        lpi8_lamp_out <= chan_mem[sw_recall ? sw_chan : channel_rot_in].lpi8;
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (powered && fmt_cfg && ((press.store && setup_mode_out) || sw_store))
      chan_mem[sw_store ? sw_chan : channel_rot_in] <= '{form_len_out, tabs, lpi8_lamp_out};
  end

  always_ff @(posedge clk_in) begin
    if (powered && fmt_cfg && ((press.store && setup_mode_out) || sw_store))
      last_chan <= sw_store ? sw_chan : channel_rot_in;
    else if (powered && fmt_cfg && ((press.recall && setup_mode_out) || sw_recall))
      last_chan <= sw_recall ? sw_chan : channel_rot_in;
  end

  always_ff @(posedge clk_in) begin
    if (powered)
      line_count_nv <= line_count_out;
  end

  // ==========================================================
  // register read port: data one cycle after the strobe
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in)
      rdata_out <= 16'h0;
    else if (rd_in) begin
      unique case (addr_in)
        `PVF_REG_FORM_LEN: rdata_out <= {9'h0, form_len_out};
        `PVF_REG_TAB:      rdata_out <= {7'h0, tab_here_out, 1'b0, line_count_out};
        `PVF_REG_SPACING:  rdata_out <= {15'h0, lpi8_lamp_out};
        `PVF_REG_CHAN_CMD: rdata_out <= {13'h0, last_chan};
        `PVF_REG_STATUS:   rdata_out <= {6'h0, counting, armed, setup_mode_out,
                                         line_count_out};
        `PVF_REG_SETTINGS: rdata_out <= {7'h0, sw[6:3], parallel_out, parity_out,
                                         1'b0, sw[2:0] == 3'h7};
        default:           rdata_out <= 16'h0;
      endcase
    end else
      rdata_out <= 16'h0;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);

  rate_decode_a: assert property (
    ##1 sw[2:0] == 3'h2 && $stable(sw) |=> baud_out == 14'd300)
    else $error("rate code 2 not decoded as 300");
  alt_rate_a: assert property (
    sw[2:0] == 3'h5 && alt_rate_option_in |=> baud_out == 14'd600)
    else $error("alternate rate not 600");
  no_selftest_a: assert property (
    sw[2:0] == 3'h7 |=> !self_test_run_out)
    else $error("self-test running with parallel input");
  parity_map_a: assert property (
    sw[3] && !sw[4] |=> parity_out == PVF_PAR_EVEN)
    else $error("even parity not decoded");
  lf_override_a: assert property (
    sw[5] |=> !auto_lf_out)
    else $error("auto line feed not suppressed");
  perf_skip_a: assert property (
    !sw[6] |=> perf_skip_out)
    else $error("perforation skip not enabled");
  length_range_a: assert property (
    powered && $changed(form_len_out) |-> len_ok(form_len_out))
    else $error("form length outside 4..112");
  top_clear_a: assert property (
    powered && setup_mode_out && press.mark_top && !counting
    && config_in != PVF_BASIC |=> line_count_out == 7'h0)
    else $error("top of form did not clear counter");
  commit_len_a: assert property (
    powered && press.normal && armed && len_ok(line_count_out) && !press.recall
    && !sw_recall && !(wr_in && addr_in == `PVF_REG_FORM_LEN)
    |=> form_len_out == $past(line_count_out))
    else $error("counted length not committed");
  lpi_toggle_a: assert property (
    powered && press.lpi8 && !press.recall && !sw_recall
    |=> lpi8_lamp_out != $past(lpi8_lamp_out))
    else $error("lpi button did not toggle");
  one_action_a: assert property (
    press.tab_set |-> $past(buttons_in.tab_set) ##1 !press.tab_set)
    else $error("button acted twice");
  store_gate_a: assert property (
    press.store && !setup_mode_out && !sw_store |=> $stable(last_chan))
    else $error("store acted outside setup");
  read_idle_a: assert property (
    !rd_in |=> rdata_out == 16'h0)
    else $error("read data outside answer cycle");

  store_cov: cover property (press.store && setup_mode_out && fmt_cfg);
  recall_cov: cover property (press.recall && setup_mode_out && fmt_cfg);
  commit_cov: cover property (press.normal && armed);
  tab_cov: cover property (setup_mode_out && press.tab);

endmodule

// ===== design/pvf_consts.svh
/*
 * Constants for the panel configuration and vertical format block:
 * register offsets, field positions, reset values and timing counts.
 * Assumes a 10 MHz clock and a 16-bit word register port.
 */
`ifndef PVF_CONSTS_SVH
`define PVF_CONSTS_SVH

// ==========================================================
// register offsets
`define PVF_REG_FORM_LEN   4'h0
`define PVF_REG_TAB        4'h1
`define PVF_REG_SPACING    4'h2
`define PVF_REG_CHAN_CMD   4'h3
`define PVF_REG_STATUS     4'h4
`define PVF_REG_SETTINGS   4'h5

// ==========================================================
// field positions
`define PVF_TAB_SET_BIT    8
`define PVF_CMD_STORE_BIT  4
`define PVF_CMD_RECALL_BIT 5

// ==========================================================
// form lengths in lines
`define PVF_LEN_MIN        7'h04
`define PVF_LEN_MAX        7'h70
`define PVF_LEN_RESET      7'h42
`define PVF_MAX_LINES      112

// ==========================================================
// timing: debounce sample period
`define PVF_CLK_HZ         10000000
`define PVF_DEB_MS         5
`define PVF_DEB_CYCLES     ((`PVF_CLK_HZ / 1000) * `PVF_DEB_MS)

`endif

// ===== design/pvf_pkg.sv
/*
 * Types shared by the panel configuration and vertical format block.
 * Assumes the constants header is included by the design file.
 */
package pvf_pkg;

  typedef enum logic [2:0] {
    PVF_BASIC      = 3'h0,
    PVF_FIXED      = 3'h1,
    PVF_FIXED_COMP = 3'h2,
    PVF_FMT        = 3'h3,
    PVF_FMT_COMP   = 3'h4
  } pvf_config_t;

  typedef enum logic [1:0] {
    PVF_PAR_IGNORE = 2'h0,
    PVF_PAR_EVEN   = 2'h1,
    PVF_PAR_ODD    = 2'h2
  } pvf_parity_t;

  // one vertical format: length, tabs, spacing
  typedef struct packed {
    logic [6:0]   len;
    logic [111:0] tabs;
    logic         lpi8;
  } pvf_format_t;

  // debounced buttons
  typedef struct packed {
    logic setup;
    logic normal;
    logic tab_set;
    logic tab;
    logic tab_clear;
    logic mark_top;
    logic line_feed;
    logic lpi8;
    logic store;
    logic recall;
  } pvf_buttons_t;

endpackage

// ===== verif/pvf_panel_model.sv
/*
 * Operator panel model: presses one push button at a time, with one
 * cycle of contact chatter, holds it, then releases it for as long.
 * Assumes the bench raises req_in for one cycle only while busy_out is low.
 */
`timescale 1ns/100ps

module pvf_panel_model
  import pvf_pkg::*;
#(
  parameter int HOLD = 24
) (
  // clock
  input  wire logic       clk_in,
  // press request, button bit index 0 (recall) .. 9 (setup)
  input  wire logic       req_in,
  input  wire logic [3:0] btn_in,
  // to the panel block
  output pvf_buttons_t    buttons_out,
  output logic            busy_out
);
  int         cnt  = 0;
  logic [9:0] mask = 10'h000;

  // ==========================================================
  // press sequencing
  always_ff @(posedge clk_in) begin
    if (req_in && cnt == 0) begin
      mask <= 10'h001 << btn_in;
      cnt  <= 2 * HOLD;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end

  // contacts bounce open once right after closing, as real ones do
  assign buttons_out = (cnt > HOLD && cnt != 2 * HOLD - 1) ? mask : 10'h000;
  assign busy_out    = (cnt != 0);
endmodule

// ===== verif/testbench.sv
/*
 * Self-checking bench for the panel format block: switch decode, panel
 * button sequences and register access on three configurations.
 * Assumes the panel model beside it and a 10 MHz clock.
 */
`timescale 1ns/100ps
`include "pvf_consts.svh"

module testbench
  import pvf_pkg::*;
;
  localparam int DEB = 2;
  localparam logic [76:0] LENS = {7'h42, 7'h3c, 7'h36, 7'h30, 7'h2a,
                                  7'h24, 7'h1e, 7'h18, 7'h12, 7'h0c, 7'h06};
  localparam int SETUP = 9, NORMAL = 8, TSET = 7, TAB = 6, TCLR = 5;
  localparam int TOP = 4, LF = 3, LPI = 2, STORE = 1, RECALL = 0;

  logic         clk_in    = 1'b0;
  logic         resetn_in = 1'b0;
  pvf_config_t  cfg       = PVF_FIXED;
  logic         alt       = 1'b0;
  logic         online    = 1'b0;
  logic [6:0]   pencil    = 7'h00;
  logic [3:0]   len_rot   = 4'h0;
  logic [2:0]   chan_rot  = 3'h0;
  logic         line_adv  = 1'b0;
  logic [3:0]   addr      = 4'h0;
  logic [15:0]  wdata     = 16'h0000;
  logic         wr_s      = 1'b0;
  logic         rd_s      = 1'b0;
  logic         req       = 1'b0;
  logic [3:0]   btn       = 4'h0;
  pvf_buttons_t buttons;
  logic         busy;
  logic [15:0]  rdata;
  logic [13:0]  baud;
  logic         par_in, auto_lf, perf, st_run, setup, lamp, tab_here;
  pvf_parity_t  parity;
  logic [6:0]   flen, lcnt;
  int           errors      = 0;
  int           checks_done = 0;
  int           std_rate[8] = '{110, 150, 300, 1200, 2400, 4800, 9600, 0};
  logic [3:0]   par_sw[4]   = '{4'h0, 4'h3, 4'h1, 4'hc};
  pvf_parity_t  par_exp[4]  = '{PVF_PAR_IGNORE, PVF_PAR_ODD, PVF_PAR_EVEN, PVF_PAR_IGNORE};

  pvf_panel_model PANEL (.clk_in(clk_in), .req_in(req), .btn_in(btn),
                         .buttons_out(buttons), .busy_out(busy));

  pvf_panel_format #(.DEB_CYCLES(DEB), .FIXED_LENS(LENS)) DUT (
    .clk_in(clk_in), .resetn_in(resetn_in), .config_in(cfg),
    .alt_rate_option_in(alt), .online_in(online), .pencil_in(pencil),
    .form_len_rot_in(len_rot), .channel_rot_in(chan_rot), .buttons_in(buttons),
    .line_adv_in(line_adv), .addr_in(addr), .wdata_in(wdata), .wr_in(wr_s),
    .rd_in(rd_s), .rdata_out(rdata), .baud_out(baud), .parallel_out(par_in),
    .parity_out(parity), .auto_lf_out(auto_lf), .perf_skip_out(perf),
    .self_test_run_out(st_run), .setup_mode_out(setup), .lpi8_lamp_out(lamp),
    .form_len_out(flen), .line_count_out(lcnt), .tab_here_out(tab_here));

  // ==========================================================
  // helpers
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
  endtask

  // one whole press and release, then time for the action to land
  task automatic press(input int b);
    @(posedge clk_in);
    req <= 1'b1;
    btn <= b[3:0];
    @(posedge clk_in);
    req <= 1'b0;
    // busy shows only from the edge after the model took the request
    @(posedge clk_in);
    for (int i = 0; i < 100 && busy; i++) @(posedge clk_in);
    cyc(8);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk_in);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk_in);
    wr_s  <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdc(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk_in);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    #1;
    chk("read data", rdata, exp);
  endtask

  task automatic sw(input logic [6:0] v);
    @(posedge clk_in);
    pencil <= v;
    cyc(16);
  endtask

  task automatic boot(input pvf_config_t c);
    @(posedge clk_in);
    resetn_in <= 1'b0;
    cfg       <= c;
    cyc(3);
    resetn_in <= 1'b1;
    cyc(16);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ==========================================================
  // clock and watchdog
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  // about eight times the expected run
  initial begin
    #2000000;
    errors++;
    tally_and_finish();
  end

  // ==========================================================
  // tests
  initial begin
    cyc(3);
    resetn_in <= 1'b1;
    cyc(16);
    chk("auto line feed", auto_lf, 1'b1);
    chk("perf skip", perf, 1'b1);
    chk("lamp", lamp, 1'b0);
    chk("line count", lcnt, 7'h00);
    chk("form length", flen, 7'h42);
    for (int a = 0; a < 2; a++) begin
      for (int c = 0; c < 8; c++) begin
        @(posedge clk_in);
        alt <= a[0];
        sw({4'h0, c[2:0]});
        chk("baud", baud, (a == 1 && c == 1) ? 16'd200 :
            (a == 1 && c == 5) ? 16'd600 : 16'(std_rate[c]));
        chk("parallel", par_in, c == 7);
      end
    end
    for (int j = 0; j < 4; j++) begin
      sw({par_sw[j], 3'h0});
      chk("parity", parity, par_exp[j]);
      chk("auto line feed", auto_lf, j != 3);
      chk("perf skip", perf, j != 3);
    end
    press(LPI);
    chk("lamp", lamp, 1'b1);
    press(LPI);
    chk("lamp", lamp, 1'b0);
    sw(7'h07);
    online <= 1'b1;
    press(SETUP);
    chk("setup", setup, 1'b1);
    chk("self test", st_run, 1'b0);
    sw(7'h00);
    chk("self test", st_run, 1'b1);
    // programmed length with tabs moved around mid-count
    press(TOP);
    chk("line count", lcnt, 7'h00);
    press(LF);
    press(LF);
    chk("line count", lcnt, 7'h02);
    press(TSET);
    chk("tab here", tab_here, 1'b1);
    press(LF);
    chk("tab here", tab_here, 1'b0);
    press(TAB);
    chk("line count", lcnt, 7'h00);
    press(TAB);
    chk("line count", lcnt, 7'h02);
    press(LF);
    press(LF);
    press(TOP);
    press(NORMAL);
    chk("form length", flen, 7'h04);
    chk("setup", setup, 1'b0);
    // single top press: leaving setup commits nothing
    press(SETUP);
    press(TOP);
    press(LF);
    press(LF);
    chk("tab here", tab_here, 1'b1);
    press(TCLR);
    chk("tab here", tab_here, 1'b0);
    press(NORMAL);
    chk("form length", flen, 7'h04);
    wr(`PVF_REG_FORM_LEN, 16'h0003);
    rdc(`PVF_REG_FORM_LEN, 16'h0004);
    wr(`PVF_REG_FORM_LEN, 16'h0070);
    rdc(`PVF_REG_FORM_LEN, 16'h0070);
    wr(`PVF_REG_FORM_LEN, 16'h0071);
    rdc(`PVF_REG_FORM_LEN, 16'h0070);
    rdc(4'hf, 16'h0000);
    press(SETUP);
    len_rot <= 4'h5;
    press(TOP);
    chk("form length", flen, LENS[28 +: 7]);
    wr(`PVF_REG_TAB, 16'h0100);
    cyc(2);
    chk("tab here", tab_here, 1'b1);
    press(NORMAL);
    boot(PVF_FIXED);
    chk("form length", flen, LENS[28 +: 7]);
    chk("tab here", tab_here, 1'b0);
    chk("line count", lcnt, 7'h00);
    // paper advance wraps the counter at the fixed length of 30
    @(posedge clk_in);
    line_adv <= 1'b1;
    cyc(31);
    line_adv <= 1'b0;
    cyc(1);
    chk("line count", lcnt, 7'h01);
    // basic: software length only, lost at power-up
    boot(PVF_BASIC);
    chk("form length", flen, 7'h42);
    wr(`PVF_REG_FORM_LEN, 16'h0028);
    rdc(`PVF_REG_FORM_LEN, 16'h0028);
    press(SETUP);
    press(TOP);
    chk("form length", flen, 7'h28);
    press(NORMAL);
    boot(PVF_BASIC);
    chk("form length", flen, 7'h42);
    // strap moved while powered only to seed channel 0 before a cold start
    cfg <= PVF_FMT;
    wr(`PVF_REG_CHAN_CMD, 16'h0010);
    // format store: channels, setup gating, retention
    boot(PVF_FMT);
    chk("form length", flen, 7'h42);
    wr(`PVF_REG_FORM_LEN, 16'h0014);
    wr(`PVF_REG_SPACING, 16'h0001);
    wr(`PVF_REG_CHAN_CMD, 16'h0013);
    wr(`PVF_REG_FORM_LEN, 16'h001e);
    wr(`PVF_REG_SPACING, 16'h0000);
    chan_rot <= 3'h3;
    press(RECALL);
    chk("form length", flen, 7'h1e);
    press(SETUP);
    press(RECALL);
    chk("form length", flen, 7'h14);
    chk("lamp", lamp, 1'b1);
    chan_rot <= 3'h6;
    wr(`PVF_REG_FORM_LEN, 16'h0032);
    press(STORE);
    wr(`PVF_REG_FORM_LEN, 16'h000a);
    press(RECALL);
    chk("form length", flen, 7'h32);
    press(NORMAL);
    boot(PVF_FMT);
    chk("form length", flen, 7'h32);
    tally_and_finish();
  end
endmodule
